// >>> hdl/sensor_spi_frame_port.sv
// subordinate spi frame port with status byte and crc-8
// Contract
// - device is always subordinate; master drives sck and sets the speed
// - select is active low; device takes part only while it is low
// - answer goes out next frame as status, two data bytes, crc
// - full duplex: new command in while previous answer goes out
// - crc-8 with polynomial 0x1D and seed 0xFF on both streams
// - crc over a whole good frame leaves residue 0xC4
// - crc byte is last and covers all earlier bytes per direction
// - command byte holds 7-bit word address plus read-or-write flag
// - every incoming frame has its crc checked, read or write
// - writes happen only after a good crc; bad frames write nothing
// - reads may run before the crc check completes
// - crc error flag set in next status after a failed check
// - rolling counter resets to 0, counts 1 to 15, wraps to 1
// - diagnosis flags show errors of first and second diagnosis registers
// - diagnosis flags update only on measurement reads outside programming mode
// - new-sample flag is one only for a not yet delivered sample
`timescale 1ns/1ps
module sensor_spi_frame_port
    import sensor_spi_pkg::*;
(
    input wire logic mclk, // system clock, 100 MHz
    input wire logic srst, // reset, high; synchronous in mclk, asynchronous for the frame holder
    input wire logic ce, // clock enable, freezes mclk state when low
    input wire logic sck, // spi serial clock from the master
    input wire logic select_n, // spi chip select, active low
    input wire logic mosi, // spi master out
    output logic miso, // spi master in, data
    output logic miso_oe, // spi master in, drive enable
    output logic [6:0] reg_addr, // register word address
    output logic [15:0] reg_wdata, // register write data
    output logic reg_rd, // register read strobe
    output logic reg_wr, // register write strobe
    input wire logic [15:0] reg_rdata, // register read data, valid with reg_rd
    input wire logic prog_mode, // programming mode active
    input wire logic first_diagnosis_register, // first diagnosis register shows an error
    input wire logic second_diagnosis_register, // second diagnosis register shows an error
    input wire logic sample_update, // pulse: fresh measurement sample stored
    output logic frame_crc_error_flag, // last frame failed its crc check
    output logic [3:0] frame_rolling_counter, // rolling frame counter
    output logic link_busy // select seen low
);

    // ****************************************
    // link side receive (sck rising edge)
    // ****************************************

    logic [CNT_W-1:0] rx_cnt;
    logic [CNT_W-1:0] next_rx_cnt;
    logic [FRAME_BITS-1:0] rx_shift;
    logic [FRAME_BITS-1:0] next_rx_shift;

    // shift mosi in msb first, count bits of the frame
    always_comb begin
        next_rx_shift = {rx_shift[FRAME_BITS-2:0], mosi};
        next_rx_cnt = rx_cnt + 5'h01;
    end

    // select high clears counting and drops a partial frame
    always_ff @(posedge sck or posedge select_n) begin
        if (select_n) begin
            rx_cnt <= CNT_ZERO;
            rx_shift <= '0;
        end else begin
            rx_cnt <= next_rx_cnt;
            rx_shift <= next_rx_shift;
        end
    end

    logic [FRAME_BITS-1:0] rx_word;
    logic [FRAME_BITS-1:0] next_rx_word;
    logic rx_tgl;
    logic next_rx_tgl;

    // hold a complete frame and toggle to announce it
    always_comb begin
        next_rx_word = rx_word;
        next_rx_tgl = rx_tgl;
        if (rx_cnt == CNT_LAST) begin
            next_rx_word = next_rx_shift;
            next_rx_tgl = ~rx_tgl;
        end
    end

    // frame holder survives select, only system reset clears it
    always_ff @(posedge sck or posedge srst) begin
        if (srst) begin
            rx_word <= '0;
            rx_tgl <= 1'b0;
        end else begin
            rx_word <= next_rx_word;
            rx_tgl <= next_rx_tgl;
        end
    end

    // ****************************************
    // link side transmit (sck falling edge)
    // ****************************************

    logic [FRAME_BITS-1:0] tx_word;
    logic [CNT_W-1:0] tx_cnt;
    logic [CNT_W-1:0] next_tx_cnt;
    logic next_miso;

    // launch the previous answer msb first while the command comes in
    always_comb begin
        next_miso = tx_word[~tx_cnt];
        next_tx_cnt = tx_cnt + 5'h01;
    end

    // device only drives miso while selected, clock comes from master
    always_ff @(negedge sck or posedge select_n) begin
        if (select_n) begin
            tx_cnt <= CNT_ZERO;
            miso <= 1'b0;
            miso_oe <= 1'b0;
        end else begin
            tx_cnt <= next_tx_cnt;
            miso <= next_miso;
            miso_oe <= 1'b1;
        end
    end

    // ****************************************
    // crossings into mclk
    // ****************************************

    logic tgl_sync;
    logic select_sync_n;

    bit_sync #(
        .RESET_VALUE(1'b0)
    ) u_tgl_sync (
        .mclk(mclk),
        .srst(srst),
        .ce(ce),
        .din(rx_tgl),
        .dout(tgl_sync)
    );

    bit_sync #(
        .RESET_VALUE(1'b1)
    ) u_select_sync (
        .mclk(mclk),
        .srst(srst),
        .ce(ce),
        .din(select_n),
        .dout(select_sync_n)
    );

    // ****************************************
    // crc check and answer crc
    // ****************************************

    logic [7:0] rx_residue;
    logic [7:0] tx_status;
    logic [15:0] tx_data;
    logic [7:0] tx_crc_raw;

    // crc over all four received bytes
    crc8_frame #(
        .NBYTES(4)
    ) u_rx_crc (
        .data(rx_word),
        .crc(rx_residue)
    );

    // crc over status and data of the answer
    crc8_frame #(
        .NBYTES(3)
    ) u_tx_crc (
        .data({tx_status, tx_data}),
        .crc(tx_crc_raw)
    );

    // answer word, held stable between frames
    assign tx_word = {tx_status, tx_data, tx_crc_raw ^ CRC_XOROUT};

    // ****************************************
    // frame sequencer
    // ****************************************

    typedef enum logic {
        ST_IDLE,
        ST_EXEC
    } seq_e;

    seq_e state;
    seq_e next_state;
    logic tgl_seen;
    logic next_tgl_seen;
    logic cmd_read;
    logic next_cmd_read;
    logic crc_ok;
    logic next_crc_ok;
    logic next_reg_rd;
    logic next_reg_wr;
    logic [6:0] next_reg_addr;
    logic [15:0] next_reg_wdata;
    logic next_link_busy;
    logic frame_done;

    assign frame_done = tgl_sync ^ tgl_seen;

    // take a frame, read at once, write only after a good crc
    always_comb begin
        next_state = state;
        next_tgl_seen = tgl_seen;
        next_cmd_read = cmd_read;
        next_crc_ok = crc_ok;
        next_reg_rd = 1'b0;
        next_reg_wr = 1'b0;
        next_reg_addr = reg_addr;
        next_reg_wdata = reg_wdata;
        next_link_busy = ~select_sync_n;
        unique case (state)
            ST_IDLE: begin
                if (frame_done) begin
                    next_tgl_seen = tgl_sync;
                    next_cmd_read = rx_word[HEAD_LSB + CMD_RW_BIT];
                    next_reg_addr = rx_word[HEAD_LSB + CMD_ADDR_MSB:HEAD_LSB + CMD_ADDR_LSB];
                    next_reg_wdata = rx_word[DATA_MSB:DATA_LSB];
                    next_crc_ok = (rx_residue == CRC_RESIDUE);
                    next_reg_rd = rx_word[HEAD_LSB + CMD_RW_BIT];
                    next_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                next_reg_wr = ~cmd_read & crc_ok;
                next_state = ST_IDLE;
            end
        endcase
    end

    // register the sequencer
    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= ST_IDLE;
            tgl_seen <= 1'b0;
            cmd_read <= 1'b0;
            crc_ok <= 1'b0;
            reg_rd <= 1'b0;
            reg_wr <= 1'b0;
            reg_addr <= ADDR_RESET;
            reg_wdata <= DATA_NONE;
            link_busy <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            tgl_seen <= next_tgl_seen;
            cmd_read <= next_cmd_read;
            crc_ok <= next_crc_ok;
            reg_rd <= next_reg_rd;
            reg_wr <= next_reg_wr;
            reg_addr <= next_reg_addr;
            reg_wdata <= next_reg_wdata;
            link_busy <= next_link_busy;
        end
    end

    // ****************************************
    // status byte and answer data
    // ****************************************

    logic unread;
    logic next_unread;
    logic diag_first;
    logic next_diag_first;
    logic diag_second;
    logic next_diag_second;
    logic next_crc_error;
    logic [3:0] next_rc;
    logic [7:0] next_tx_status;
    logic [15:0] next_tx_data;
    logic meas_read;

    // measurement reads outside programming mode carry diagnosis and new
    assign meas_read = cmd_read & ~prog_mode & (reg_addr >= MEAS_ADDR_FIRST) & (reg_addr <= MEAS_ADDR_LAST);

    // build the answer for the next frame
    always_comb begin
        next_unread = unread | sample_update;
        next_diag_first = diag_first;
        next_diag_second = diag_second;
        next_crc_error = frame_crc_error_flag;
        next_rc = frame_rolling_counter;
        next_tx_status = tx_status;
        next_tx_data = tx_data;
        if (state == ST_EXEC) begin
            next_crc_error = ~crc_ok;
            next_rc = (frame_rolling_counter == RC_LAST) ? RC_FIRST : frame_rolling_counter + 4'h1;
            next_tx_data = cmd_read ? reg_rdata : DATA_NONE;
            next_tx_status[STAT_NEW_BIT] = 1'b0;
            if (meas_read) begin
                next_diag_first = first_diagnosis_register;
                next_diag_second = second_diagnosis_register;
                next_tx_status[STAT_NEW_BIT] = unread;
                next_unread = sample_update;
            end
            next_tx_status[STAT_RC_MSB:STAT_RC_LSB] = next_rc;
            next_tx_status[STAT_DIAG_FIRST_BIT] = next_diag_first;
            next_tx_status[STAT_DIAG_SECOND_BIT] = next_diag_second;
            next_tx_status[STAT_FRAME_CRC_ERROR_FLAG_BIT] = next_crc_error;
        end
    end

    // register status; answer changes only right after a frame ends
    always_ff @(posedge mclk) begin
        if (srst) begin
            unread <= 1'b0;
            diag_first <= 1'b0;
            diag_second <= 1'b0;
            frame_crc_error_flag <= 1'b0;
            frame_rolling_counter <= RC_RESET;
            tx_status <= STATUS_RESET;
            tx_data <= DATA_NONE;
        end else if (ce) begin
            unread <= next_unread;
            diag_first <= next_diag_first;
            diag_second <= next_diag_second;
            frame_crc_error_flag <= next_crc_error;
            frame_rolling_counter <= next_rc;
            tx_status <= next_tx_status;
            tx_data <= next_tx_data;
        end
    end

endmodule

// >>> pkg/sensor_spi_pkg.sv
// shared constants for the sensor spi frame port
package sensor_spi_pkg;

    // ****************************************
    // frame geometry
    // ****************************************
    localparam int FRAME_BITS = 32;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_LAST = 5'h1F;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam int HEAD_MSB = 31;
    localparam int HEAD_LSB = 24;
    localparam int DATA_MSB = 23;
    localparam int DATA_LSB = 8;

    // ****************************************
    // crc-8 parameters
    // ****************************************
    localparam logic [7:0] CRC_POLY = 8'h1D;
    localparam logic [7:0] CRC_SEED = 8'hFF;
    localparam logic [7:0] CRC_RESIDUE = 8'hC4;
    localparam logic [7:0] CRC_XOROUT = 8'hFF;

    // ****************************************
    // command byte layout
    // ****************************************
    localparam int CMD_RW_BIT = 7;
    localparam int CMD_ADDR_MSB = 6;
    localparam int CMD_ADDR_LSB = 0;

    // ****************************************
    // status byte layout
    // ****************************************
    localparam int STAT_RC_MSB = 7;
    localparam int STAT_RC_LSB = 4;
    localparam int STAT_DIAG_FIRST_BIT = 3;
    localparam int STAT_DIAG_SECOND_BIT = 2;
    localparam int STAT_FRAME_CRC_ERROR_FLAG_BIT = 1;
    localparam int STAT_NEW_BIT = 0;

    // ****************************************
    // rolling counter and reset values
    // ****************************************
    localparam logic [3:0] RC_RESET = 4'h0;
    localparam logic [3:0] RC_FIRST = 4'h1;
    localparam logic [3:0] RC_LAST = 4'hF;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [15:0] DATA_NONE = 16'h0000;
    localparam logic [6:0] ADDR_RESET = 7'h00;

    // ****************************************
    // measurement channel word addresses
    // ****************************************
    localparam logic [6:0] MEAS_ADDR_FIRST = 7'h00;
    localparam logic [6:0] MEAS_ADDR_LAST = 7'h03;

endpackage

// >>> hdl/bit_sync.sv
// two flip-flop level synchroniser into the mclk domain
`timescale 1ns/1ps
module bit_sync
    import sensor_spi_pkg::*;
#(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic mclk, // system clock
    input wire logic srst, // synchronous reset, high
    input wire logic ce, // clock enable
    input wire logic din, // asynchronous level
    output logic dout // synchronised level
);

    logic stage1;
    logic next_stage1;
    logic next_dout;

    // first stage feeds only the second stage
    always_comb begin
        next_stage1 = din;
        next_dout = stage1;
    end

    // register both stages
    always_ff @(posedge mclk) begin
        if (srst) begin
            stage1 <= RESET_VALUE;
            dout <= RESET_VALUE;
        end else if (ce) begin
            stage1 <= next_stage1;
            dout <= next_dout;
        end
    end

endmodule

// >>> hdl/crc8_frame.sv
// combinational crc-8 over a whole number of bytes, msb first
`timescale 1ns/1ps
module crc8_frame
    import sensor_spi_pkg::*;
#(
    parameter int NBYTES = 3
) (
    input wire logic [8*NBYTES-1:0] data, // bytes, first byte in the top bits
    output logic [7:0] crc // crc register after the last bit
);

    // one bit through the shift register
    function automatic logic [7:0] crc_bit(input logic [7:0] cur, input logic din);
        logic [7:0] shifted;
        shifted = {cur[6:0], 1'b0};
        crc_bit = (cur[7] ^ din) ? (shifted ^ CRC_POLY) : shifted;
    endfunction

    // walk every bit from the seed
    always_comb begin
        crc = CRC_SEED;
        for (int i = 8 * NBYTES - 1; i >= 0; i--) begin
            crc = crc_bit(crc, data[i]);
        end
    end

endmodule

// >>> testbench/sensor_spi_frame_port_chk.sv
// assertions on the ports of the sensor spi frame port
`timescale 1ns/1ps
module sensor_spi_frame_port_chk
    import sensor_spi_pkg::*;
(
    input wire logic mclk, // system clock
    input wire logic srst, // synchronous reset, high
    input wire logic ce, // clock enable
    input wire logic select_n, // chip select, active low
    input wire logic miso_oe, // miso drive enable
    input wire logic reg_rd, // read strobe
    input wire logic reg_wr, // write strobe
    input wire logic frame_crc_error_flag, // crc error flag
    input wire logic [3:0] frame_rolling_counter, // frame counter
    input wire logic link_busy // select seen low
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    // ****************************************
    // link and strobes
    // ****************************************
    oe_select_a: assert property (select_n |-> !miso_oe) else $error("miso driven while deselected");
    busy_low_a: assert property ((ce && !select_n) [*4] |-> link_busy) else $error("busy missing");
    busy_idle_a: assert property ((ce && select_n) [*4] |-> !link_busy) else $error("busy stuck");
    strobe_excl_a: assert property (reg_rd |-> !reg_wr) else $error("read and write together");
    rd_once_a: assert property (reg_rd |=> !reg_rd [*8]) else $error("read strobe repeated");
    wr_once_a: assert property (reg_wr |=> !reg_wr [*8]) else $error("write strobe repeated");
    wr_crc_ok_a: assert property (reg_wr |-> !frame_crc_error_flag) else $error("write on bad crc");

    // ****************************************
    // rolling counter
    // ****************************************
    rc_step_a: assert property ($changed(frame_rolling_counter) |-> frame_rolling_counter ==
        (($past(frame_rolling_counter) == 4'hF) ? 4'h1 : $past(frame_rolling_counter) + 4'h1))
        else $error("counter step wrong");
    rc_nonzero_a: assert property (frame_rolling_counter != 4'h0 |=> frame_rolling_counter != 4'h0)
        else $error("counter back to zero");
    rd_steps_a: assert property (reg_rd |=> $changed(frame_rolling_counter)) else $error("no step");
    wr_steps_a: assert property (reg_wr |-> $changed(frame_rolling_counter)) else $error("no step");

    // main scenarios
    cover property (reg_wr);
    cover property ($rose(frame_crc_error_flag));
    cover property ($past(frame_rolling_counter) == 4'hF && frame_rolling_counter == 4'h1);
endmodule

bind sensor_spi_frame_port sensor_spi_frame_port_chk i_chk (.mclk(mclk), .srst(srst), .ce(ce),
    .select_n(select_n), .miso_oe(miso_oe), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .frame_crc_error_flag(frame_crc_error_flag), .frame_rolling_counter(frame_rolling_counter),
    .link_busy(link_busy));

// >>> testbench/spi_master_model.sv
// spi master model on the far side of the sensor frame port
`timescale 1ns/1ps
module spi_master_model (
    output logic sck, // serial clock, idles high
    output logic select_n, // chip select, active low
    output logic mosi, // master out
    input wire logic miso, // master in
    input wire logic miso_oe // device drive enable
);
    int half = 32; // half sck period in ns
    int gap = 200; // deselect time between frames
    int oe_bad = 0; // sampling edges without miso driven

    // idle bus: clock high, only this sensor's select
    // select rises a little late so the link counters see a real clearing edge
    initial begin
        sck = 1'b1;
        mosi = 1'b1;
        #1;
        select_n = 1'b1;
    end

    // one frame of nbits, msb first; miso taken on each rise
    task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
        rx = 32'h0;
        select_n = 1'b0;
        for (int i = 31; i > 31 - nbits; i--) begin
            #(half);
            sck = 1'b0;
            mosi = tx[i];
            #(half);
            sck = 1'b1;
            rx[i] = miso;
            if (miso_oe !== 1'b1) oe_bad++;
        end
        #(half);
        select_n = 1'b1;
        mosi = ~mosi; // released line shows no stale bit
        #(gap);
    endtask
endmodule

// >>> testbench/tb.sv
// self-checking bench for the sensor spi frame port
`timescale 1ns/1ps
module tb;
    import sensor_spi_pkg::*;
    logic mclk, srst, ce, sck, select_n, mosi, miso, miso_oe, reg_rd, reg_wr, prog_mode;
    logic d1, d2, sample_update, crc_flag, busy, diag_f, diag_s, new_flag;
    logic [6:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, last_wd;
    logic [3:0] rc_out, rc;
    logic [31:0] exp_ans, rx;
    int failures = 0;
    int check_count = 0;
    int rd_n = 0;
    int wr_n = 0;
    int cycles = 0;

    sensor_spi_frame_port i_sensor_spi_frame_port (.mclk(mclk), .srst(srst), .ce(ce), .sck(sck),
        .select_n(select_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
        .prog_mode(prog_mode), .first_diagnosis_register(d1), .second_diagnosis_register(d2),
        .sample_update(sample_update), .frame_crc_error_flag(crc_flag),
        .frame_rolling_counter(rc_out), .link_busy(busy));
    spi_master_model i_spi_master_model (.sck(sck), .select_n(select_n), .mosi(mosi), .miso(miso),
        .miso_oe(miso_oe));

    // 100 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // register file stand-in: data derived from the address
    always @(negedge mclk) begin
        reg_rdata <= {9'h160, reg_addr};
    end

    // strobe counting and hang guard
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (reg_rd) rd_n <= rd_n + 1;
        if (reg_wr) wr_n <= wr_n + 1;
        if (reg_wr) last_wd <= reg_wdata;
        if (cycles == 20000) begin
            failures = failures + 1;
            print_verdict();
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    function automatic logic [7:0] crc8(input logic [31:0] d, input int nb);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 8 * nb - 1; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h1D : 8'h00);
        end
        return c;
    endfunction

    // one full frame: judge the answer and the strobes, then predict the next answer
    task automatic frame(input logic rd, input logic [6:0] a, input logic [15:0] wd, input logic bad);
        logic [23:0] body;
        logic [7:0] st;
        int rd0;
        int wr0;
        body = {rd, a, wd};
        rd0 = rd_n;
        wr0 = wr_n;
        i_spi_master_model.xfer({body, crc8({8'h00, body}, 3) ^ 8'hFF ^ {7'h0, bad}}, 32, rx);
        repeat (2) @(negedge mclk);
        check(rx, exp_ans);
        check(crc8(rx, 4), 8'hC4);
        rc = (rc == 4'hF) ? 4'h1 : rc + 4'h1;
        check(rc_out, rc);
        check(crc_flag, bad);
        check(rd_n - rd0, 32'(rd));
        check(wr_n - wr0, 32'(!rd && !bad));
        check(reg_addr, a);
        if (!rd && !bad) check(last_wd, wd);
        check(i_spi_master_model.oe_bad, 0);
        st = {rc, diag_f, diag_s, bad, 1'b0};
        if (rd && a <= MEAS_ADDR_LAST && !prog_mode) begin
            st[3:0] = {d1, d2, bad, new_flag};
            diag_f = d1;
            diag_s = d2;
            new_flag = 1'b0;
        end
        exp_ans[31:8] = {st, rd ? {9'h160, a} : 16'h0000};
        exp_ans[7:0] = crc8({8'h00, exp_ans[31:8]}, 3) ^ 8'hFF;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic reset_values();
        check({rc_out, crc_flag, reg_rd, reg_wr, miso_oe, miso, busy}, 32'h0);
        check({reg_addr, reg_wdata}, 32'h0);
        exp_ans = {24'h0, crc8(32'h0, 3) ^ 8'hFF};
    endtask

    task automatic measurement_read();
        d1 = 1'b1;
        @(negedge mclk) sample_update = 1'b1;
        @(negedge mclk) sample_update = 1'b0;
        new_flag = 1'b1;
        frame(1'b1, 7'h01, 16'h0000, 1'b0);
        frame(1'b1, 7'h01, 16'h0000, 1'b0);
        frame(1'b1, 7'h03, 16'h0000, 1'b0);
    endtask

    task automatic write_and_crc();
        frame(1'b0, 7'h05, 16'hBEEF, 1'b0);
        frame(1'b0, 7'h06, 16'h1234, 1'b1);
        frame(1'b1, 7'h02, 16'h0000, 1'b1);
        frame(1'b0, 7'h7F, 16'hFFFF, 1'b0);
    endtask

    task automatic prog_read();
        prog_mode = 1'b1;
        d1 = 1'b0;
        d2 = 1'b1;
        frame(1'b1, 7'h20, 16'h0000, 1'b0);
        frame(1'b1, 7'h00, 16'h0000, 1'b0);
        prog_mode = 1'b0;
    endtask

    task automatic abort_frame();
        int rd0;
        rd0 = rd_n;
        i_spi_master_model.xfer(32'hFFFF_FFFF, 12, rx);
        repeat (2) @(negedge mclk);
        check(rc_out, rc);
        check(rd_n - rd0, 0);
        frame(1'b1, 7'h00, 16'h0000, 1'b0);
    endtask

    task automatic wrap_count();
        for (int i = 0; i < 17; i++) begin
            frame(1'b1, 7'h10, 16'h0000, 1'b0);
        end
    endtask

    initial begin
        srst = 1'b0;
        ce = 1'b1;
        prog_mode = 1'b0;
        d1 = 1'b0;
        d2 = 1'b0;
        sample_update = 1'b0;
        rc = 4'h0;
        diag_f = 1'b0;
        diag_s = 1'b0;
        new_flag = 1'b0;
        // a real rising edge so the frame holder clear is never missed
        #1;
        srst = 1'b1;
        repeat (4) @(negedge mclk);
        srst = 1'b0;
        reset_values();
        measurement_read();
        write_and_crc();
        prog_read();
        abort_frame();
        wrap_count();
        print_verdict();
    end
endmodule
